// ===== dv/dlpx_mem_model.sv
`default_nettype none
module dlpx_mem_model
  import dlpx_pkg::*;
#(
  parameter int MOD_NCK = 24
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic cke_in,
  input wire logic cmd_valid_in,
  input wire dlpx_cmd_t cmd_in,
  input wire logic mem_reset_n_in,
  output logic path_on_out,
  output logic early_out
);
  int busy;
  int off;
  logic first;
  //////////////////////////////////////////////////////////////////
  // command path shuts update plus disable delay after power-saving entry
  always_ff @(posedge clock_in) begin
    if (srst_in || cke_in) begin
      off <= 0;
      path_on_out <= 1'b1;
    end else if (cmd_valid_in && cmd_in == DLPX_CMD_PWRSAVE_ENTER) begin
      off <= MOD_NCK + 4;
    end else if (off > 0) begin
      off <= off - 1;
      path_on_out <= (off != 1);
    end
  end
  //////////////////////////////////////////////////////////////////
  // calibration busy window; a command inside it is flagged
  always_ff @(posedge clock_in) begin
    if (srst_in || !mem_reset_n_in) begin
      busy <= 0;
      first <= 1'b1;
      early_out <= 1'b0;
    end else if (cmd_valid_in) begin
      if (busy > 0) early_out <= 1'b1;
      if (cmd_in == DLPX_CMD_ZQCL) busy <= first ? 1023 : 511;
      else busy <= (cmd_in == DLPX_CMD_ZQCS) ? 127 : 0;
      if (cmd_in == DLPX_CMD_ZQCL) first <= 1'b0;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb
  import dlpx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int XPR = 6;
  localparam int XS = 6;
  localparam int XSF = 4;
  localparam int DLLK = 16;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_valid_in = 1'b0;
  dlpx_cmd_t req_cmd_in = DLPX_CMD_NOP;
  logic parity_en_in = 1'b0;
  logic [3:0] parity_latency_in = 4'h0;
  logic abort_en_in = 1'b0;
  logic req_done_out, cmd_valid_out, cke_out, cs_n_out, ck_en_out;
  logic mem_reset_n_out, busy_out, path_on, early;
  dlpx_cmd_t cmd_out;
  dlpx_cmd_t seen_cmd = DLPX_CMD_NOP;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int t_cmd, t_rise, t_fall, t_ckon, t_ckoff, t_csup, t_csdn;
  logic cke_q = 1'b0;
  logic ck_q = 1'b0;
  logic cs_q = 1'b1;
  always #2.5 clock_in = ~clock_in;
  dlpx_lp_guard #(.RFC_NS(20), .RFC4_NS(10), .DLLK_NCK(DLLK)) u_dut (
    .clock_in(clock_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
    .req_cmd_in(req_cmd_in), .parity_en_in(parity_en_in),
    .parity_latency_in(parity_latency_in), .abort_en_in(abort_en_in),
    .req_done_out(req_done_out), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
    .cke_out(cke_out), .cs_n_out(cs_n_out), .ck_en_out(ck_en_out),
    .mem_reset_n_out(mem_reset_n_out), .busy_out(busy_out));
  dlpx_mem_model u_mem (
    .clock_in(clock_in), .srst_in(srst_in), .cke_in(cke_out),
    .cmd_valid_in(cmd_valid_out), .cmd_in(cmd_out), .mem_reset_n_in(mem_reset_n_out),
    .path_on_out(path_on), .early_out(early));
  //////////////////////////////////////////////////////////////////
  // cycle stamps of pin edges and commands, plus the hang limit
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cmd_valid_out === 1'b1) begin
      t_cmd <= cyc;
      seen_cmd <= cmd_out;
    end
    if (cke_out && !cke_q) t_rise <= cyc;
    if (!cke_out && cke_q) t_fall <= cyc;
    if (ck_en_out && !ck_q) t_ckon <= cyc;
    if (!ck_en_out && ck_q) t_ckoff <= cyc;
    if (cs_n_out && !cs_q) t_csup <= cyc;
    if (!cs_n_out && cs_q) t_csdn <= cyc;
    cke_q <= cke_out;
    ck_q <= ck_en_out;
    cs_q <= cs_n_out;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, seen);
    end
  endtask
  // hold the request until done, drop it at the next edge
  task automatic go(dlpx_cmd_t cmd);
    int n;
    n = 0;
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_cmd_in <= cmd;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (req_done_out !== 1'b1 && n < 3000);
    check("request done", n < 3000, 1);
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    #1;
  endtask
  task automatic gap(dlpx_cmd_t cmd, int ref_t, int exp);
    go(cmd);
    check("command spacing", t_cmd - ref_t, exp);
    check("command code", seen_cmd, cmd);
  endtask
  //////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check("reset pin", mem_reset_n_out, 0);
    check("busy in reset", busy_out, 1);
    go(DLPX_CMD_RESET_EXIT);
    check("reset pin released", mem_reset_n_out, 1);
    check("busy after exit", busy_out, 0);
    check("clock before cke", t_rise - t_ckon, 5);
    gap(DLPX_CMD_ZQCL, t_rise, XPR);
    gap(DLPX_CMD_ZQCL, t_cmd, 1024);
    gap(DLPX_CMD_ZQCS, t_cmd, 512);
    gap(DLPX_CMD_PLAIN, t_cmd, 128);
    $display("test reset and calibration finished");
  endtask
  task automatic t_lp(dlpx_cmd_t ent, dlpx_cmd_t ext, logic [3:0] lat, logic ab,
                      dlpx_cmd_t cmd, int exp);
    @(posedge clock_in);
    parity_en_in <= (lat != 4'h0);
    parity_latency_in <= lat;
    abort_en_in <= ab;
    go(ent);
    go(ext);
    check("clock after entry", t_ckoff - t_fall, 5 + lat);
    check("clock before exit", t_rise - t_ckon, 5);
    check("cke low", t_rise - t_fall >= 8 + (ent == DLPX_CMD_SRE) + lat, 1);
    if (exp > 0) gap(cmd, t_rise, exp);
    $display("test low power entry %0d finished", ent);
  endtask
  task automatic t_power_saving(dlpx_cmd_t cmd, int exp);
    go(DLPX_CMD_PWRSAVE_ENTER);
    repeat (40) @(posedge clock_in);
    #1;
    check("path off", path_on, 0);
    check("clock after saving entry", t_ckoff - t_fall, 28);
    go(DLPX_CMD_PWRSAVE_EXIT);
    check("clock before saving exit", t_rise - t_ckon, 5);
    check("cs low after cke", t_csup - t_rise, 3);
    check("cs low before cke", t_csdn < t_rise, 1);
    gap(cmd, t_rise, exp);
    $display("test power saving finished");
  endtask
  //////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b0;
    t_reset();
    t_lp(DLPX_CMD_SRE, DLPX_CMD_SRX, 4'h0, 1'b0, DLPX_CMD_PLAIN, XS);
    t_lp(DLPX_CMD_SRE, DLPX_CMD_SRX, 4'h3, 1'b0, DLPX_CMD_DLL, DLLK);
    t_lp(DLPX_CMD_SRE, DLPX_CMD_SRX, 4'h0, 1'b1, DLPX_CMD_PLAIN, XSF);
    t_lp(DLPX_CMD_SRE, DLPX_CMD_SRX, 4'h0, 1'b0, DLPX_CMD_ZQCS, XSF);
    t_lp(DLPX_CMD_SRE, DLPX_CMD_SRX, 4'h0, 1'b0, DLPX_CMD_MRS_FAST, XSF);
    t_lp(DLPX_CMD_PDE, DLPX_CMD_PDX, 4'h0, 1'b0, DLPX_CMD_NOP, 0);
    t_power_saving(DLPX_CMD_PLAIN, XS);
    t_power_saving(DLPX_CMD_DLL, XS + DLLK);
    check("calibration busy hit", early, 0);
    test_done();
  end
endmodule
`default_nettype wire

// ===== hdl/dlpx_consts.svh
`ifndef DLPX_CONSTS_SVH
`define DLPX_CONSTS_SVH
// clock rate and ns to cycle conversion
`define DLPX_CLK_PERIOD_NS 5
`define DLPX_CYC_CEIL(ns) (((ns) + `DLPX_CLK_PERIOD_NS - 1) / `DLPX_CLK_PERIOD_NS)
`define DLPX_CYC_FLOOR(ns) ((ns) / `DLPX_CLK_PERIOD_NS)
// calibration busy times, clocks
`define DLPX_ZQ_INIT_NCK 1024
`define DLPX_ZQ_LONG_NCK 512
`define DLPX_ZQ_SHORT_NCK 128
// exit and entry figures
`define DLPX_EXIT_EXTRA_NS 10
`define DLPX_XPR_MIN_NCK 5
`define DLPX_CK_VALID_NCK 5
`define DLPX_CK_VALID_NS 10
`define DLPX_CKE_MIN_NCK 3
`define DLPX_CKE_MIN_NS 5
`define DLPX_CKESR_EXTRA_NCK 1
`define DLPX_CPDED_NCK 4
`define DLPX_MPX_LH_NS 12
`define DLPX_MPX_MARGIN_NS 10
// plain defaults for part-dependent figures
`define DLPX_RFC_NS 260
`define DLPX_RFC4_NS 160
`define DLPX_DLLK_NCK 512
`define DLPX_MOD_NCK 24
`define DLPX_CA_SETUP_NS 1
// wait timer slots
`define DLPX_TM_GATE 0
`define DLPX_TM_XS 1
`define DLPX_TM_FAST 2
`define DLPX_TM_DLL 3
`define DLPX_TM_CKE 4
`define DLPX_TM_PHASE 5
`define DLPX_TM_NUM 6
`define DLPX_CNT_W 16
`endif

// ===== hdl/dlpx_lp_guard.sv
`include "dlpx_consts.svh"
`default_nettype none
module dlpx_lp_guard
  import dlpx_pkg::*;
#(
  parameter int RFC_NS = `DLPX_RFC_NS,
  parameter int RFC4_NS = `DLPX_RFC4_NS,
  parameter int DLLK_NCK = `DLPX_DLLK_NCK,
  parameter int MOD_NCK = `DLPX_MOD_NCK,
  parameter int CA_SETUP_NS = `DLPX_CA_SETUP_NS
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic req_valid_in,
  input wire dlpx_cmd_t req_cmd_in,
  input wire logic parity_en_in,
  input wire logic [3:0] parity_latency_in,
  input wire logic abort_en_in,
  output logic req_done_out,
  output logic cmd_valid_out,
  output var dlpx_cmd_t cmd_out,
  output logic cke_out,
  output logic cs_n_out,
  output logic ck_en_out,
  output logic mem_reset_n_out,
  output logic busy_out
);
  ////////////////////////////////////////////////////////////////////////////
  // cycle counts, ns figures rounded up except the chip select hold maximum, which is rounded down
  localparam int XS_NS = RFC_NS + `DLPX_EXIT_EXTRA_NS;
  localparam int ABORT_NS = RFC4_NS + `DLPX_EXIT_EXTRA_NS;
  localparam logic [15:0] XS_CYC = 16'(`DLPX_CYC_CEIL(XS_NS));
  localparam logic [15:0] ABORT_CYC = 16'(`DLPX_CYC_CEIL(ABORT_NS));
  localparam logic [15:0] XPR_LO = 16'(`DLPX_XPR_MIN_NCK);
  localparam logic [15:0] XPR_CYC = (XS_CYC > XPR_LO) ? XS_CYC : XPR_LO;
  localparam logic [15:0] CKV_NS_CYC = 16'(`DLPX_CYC_CEIL(`DLPX_CK_VALID_NS));
  localparam logic [15:0] CKV_LO = 16'(`DLPX_CK_VALID_NCK);
  localparam logic [15:0] CKV_CYC = (CKV_NS_CYC > CKV_LO) ? CKV_NS_CYC : CKV_LO;
  localparam logic [15:0] CKE_NS_CYC = 16'(`DLPX_CYC_CEIL(`DLPX_CKE_MIN_NS));
  localparam logic [15:0] CKE_LO = 16'(`DLPX_CKE_MIN_NCK);
  localparam logic [15:0] CKE_MIN_CYC = (CKE_NS_CYC > CKE_LO) ? CKE_NS_CYC : CKE_LO;
  localparam logic [15:0] CKESR_CYC = CKE_MIN_CYC + 16'(`DLPX_CKESR_EXTRA_NCK);
  // command path goes dark after update plus disable delay
  localparam logic [15:0] MPED_CYC = 16'(MOD_NCK + `DLPX_CPDED_NCK);
  localparam logic [15:0] MPX_S_CYC = 16'(`DLPX_CYC_CEIL(CA_SETUP_NS));
  localparam logic [15:0] WAKE_PS_CYC = (MPX_S_CYC > CKV_CYC) ? MPX_S_CYC : CKV_CYC;
  localparam logic [15:0] MPX_LH_CYC = 16'(`DLPX_CYC_CEIL(`DLPX_MPX_LH_NS));
  localparam logic [15:0] MPX_MAX_CYC = 16'(`DLPX_CYC_FLOOR(XS_NS - `DLPX_MPX_MARGIN_NS));
  localparam logic [15:0] DLL_CYC = 16'(DLLK_NCK);
  localparam logic [15:0] XMPDLL_CYC = XS_CYC + DLL_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // decode and timers
  dlpx_state_t state;
  dlpx_lp_kind_t kind;
  dlpx_cmd_t exit_cmd;
  logic init_zq;
  logic allow;
  logic take;
  logic take_act;
  logic is_entry;
  logic wake_end;
  logic [15:0] parity_cyc;
  logic [`DLPX_TM_NUM-1:0] tm_load;
  logic [`DLPX_TM_NUM-1:0] tm_done;
  logic [15:0] tm_value [`DLPX_TM_NUM];

  // load value giving an exact spacing of n cycles
  function automatic logic [15:0] ld(input logic [15:0] n);
    ld = (n == 16'h0000) ? 16'h0000 : n - 16'h0001;
  endfunction

  // one wait timer per slot; each slot guards several intervals
  for (genvar i = 0; i < `DLPX_TM_NUM; i++) begin : g_tm
    dlpx_wait_timer u_tm (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .load_in(tm_load[i]),
      .value_in(tm_value[i]),
      .done_out(tm_done[i])
    );
  end

  // parity latency only counts when parity is on
  assign parity_cyc = parity_en_in ? {12'h000, parity_latency_in} : 16'h0000;
  assign take = req_valid_in && allow && !req_done_out;
  assign take_act = take && (state == ST_ACTIVE);
  assign wake_end = (state == ST_WAKE) && tm_done[`DLPX_TM_PHASE];
  assign is_entry = (req_cmd_in == DLPX_CMD_SRE) || (req_cmd_in == DLPX_CMD_PDE) ||
                    (req_cmd_in == DLPX_CMD_PWRSAVE_ENTER);

  // exit request that matches the current low power kind
  always_comb begin
    unique case (kind)
      LPK_RESET: exit_cmd = DLPX_CMD_RESET_EXIT;
      LPK_SR: exit_cmd = DLPX_CMD_SRX;
      LPK_PD: exit_cmd = DLPX_CMD_PDX;
      LPK_PWRSAVE: exit_cmd = DLPX_CMD_PWRSAVE_EXIT;
    endcase
  end

  // request admission per state and command class
  always_comb begin
    allow = 1'b0;
    unique case (state)
      ST_RESET: allow = (req_cmd_in == DLPX_CMD_RESET_EXIT);
      ST_ACTIVE: begin
        unique case (req_cmd_in)
          DLPX_CMD_PLAIN, DLPX_CMD_SRE, DLPX_CMD_PDE, DLPX_CMD_PWRSAVE_ENTER: begin
            allow = tm_done[`DLPX_TM_GATE] && tm_done[`DLPX_TM_XS];
          end
          DLPX_CMD_DLL: begin
            allow = tm_done[`DLPX_TM_GATE] && tm_done[`DLPX_TM_XS] &&
                    tm_done[`DLPX_TM_DLL];
          end
          DLPX_CMD_ZQCL, DLPX_CMD_ZQCS, DLPX_CMD_MRS_FAST: begin
            allow = tm_done[`DLPX_TM_GATE] && tm_done[`DLPX_TM_FAST];
          end
          default: allow = 1'b0;
        endcase
      end
      ST_LP: allow = tm_done[`DLPX_TM_CKE] && (req_cmd_in == exit_cmd);
      default: allow = 1'b0;
    endcase
  end

  // timer loads on commands, entries and cke rise
  always_comb begin
    tm_load = '0;
    for (int i = 0; i < `DLPX_TM_NUM; i++) begin
      tm_value[i] = 16'h0000;
    end
    if (take_act) begin
      unique case (req_cmd_in)
        DLPX_CMD_ZQCL: begin
          tm_load[`DLPX_TM_GATE] = 1'b1;
          tm_value[`DLPX_TM_GATE] = init_zq ? ld(16'(`DLPX_ZQ_INIT_NCK))
                                            : ld(16'(`DLPX_ZQ_LONG_NCK));
        end
        DLPX_CMD_ZQCS: begin
          tm_load[`DLPX_TM_GATE] = 1'b1;
          tm_value[`DLPX_TM_GATE] = ld(16'(`DLPX_ZQ_SHORT_NCK));
        end
        DLPX_CMD_SRE, DLPX_CMD_PDE: begin
          tm_load[`DLPX_TM_PHASE] = 1'b1;
          tm_value[`DLPX_TM_PHASE] = ld(CKV_CYC + parity_cyc);
          tm_load[`DLPX_TM_CKE] = 1'b1;
          tm_value[`DLPX_TM_CKE] = (req_cmd_in == DLPX_CMD_SRE) ?
                                   ld(CKESR_CYC + parity_cyc) : ld(CKE_MIN_CYC);
        end
        DLPX_CMD_PWRSAVE_ENTER: begin
          tm_load[`DLPX_TM_PHASE] = 1'b1;
          tm_value[`DLPX_TM_PHASE] = ld(MPED_CYC);
          tm_load[`DLPX_TM_CKE] = 1'b1;
          tm_value[`DLPX_TM_CKE] = ld(CKE_MIN_CYC);
        end
        default: ;
      endcase
    end
    if (take && (state == ST_LP || state == ST_RESET)) begin
      tm_load[`DLPX_TM_PHASE] = 1'b1;
      tm_value[`DLPX_TM_PHASE] = (kind == LPK_PWRSAVE) ? ld(WAKE_PS_CYC)
                                                       : ld(CKV_CYC);
    end
    if (wake_end) begin
      unique case (kind)
        LPK_RESET: begin
          tm_load[`DLPX_TM_GATE] = 1'b1;
          tm_value[`DLPX_TM_GATE] = ld(XPR_CYC);
        end
        LPK_SR: begin
          tm_load[`DLPX_TM_XS] = 1'b1;
          tm_value[`DLPX_TM_XS] = abort_en_in ? ld(ABORT_CYC) : ld(XS_CYC);
          tm_load[`DLPX_TM_FAST] = 1'b1;
          tm_value[`DLPX_TM_FAST] = ld(ABORT_CYC);
          tm_load[`DLPX_TM_DLL] = 1'b1;
          tm_value[`DLPX_TM_DLL] = ld(DLL_CYC);
        end
        LPK_PWRSAVE: begin
          tm_load[`DLPX_TM_XS] = 1'b1;
          tm_value[`DLPX_TM_XS] = ld(XS_CYC);
          tm_load[`DLPX_TM_FAST] = 1'b1;
          tm_value[`DLPX_TM_FAST] = ld(XS_CYC);
          tm_load[`DLPX_TM_DLL] = 1'b1;
          tm_value[`DLPX_TM_DLL] = ld(XMPDLL_CYC);
          tm_load[`DLPX_TM_PHASE] = 1'b1;
          tm_value[`DLPX_TM_PHASE] = ld(MPX_LH_CYC);
        end
        LPK_PD: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= ST_RESET;
    end else begin
      unique case (state)
        ST_RESET: if (take) state <= ST_WAKE;
        ST_WAKE: begin
          if (tm_done[`DLPX_TM_PHASE]) begin
            state <= (kind == LPK_PWRSAVE) ? ST_CS_HOLD : ST_ACTIVE;
          end
        end
        ST_ACTIVE: if (take && is_entry) state <= ST_LP_HOLD;
        ST_LP_HOLD: if (tm_done[`DLPX_TM_PHASE]) state <= ST_LP;
        ST_LP: if (take) state <= ST_WAKE;
        ST_CS_HOLD: if (tm_done[`DLPX_TM_PHASE]) state <= ST_ACTIVE;
        default: state <= ST_RESET;
      endcase
    end
  end

  // remember the kind of low power condition
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      kind <= LPK_RESET;
    end else if (take_act && is_entry) begin
      unique case (req_cmd_in)
        DLPX_CMD_SRE: kind <= LPK_SR;
        DLPX_CMD_PDE: kind <= LPK_PD;
        default: kind <= LPK_PWRSAVE;
      endcase
    end
  end

  // first long calibration after reset uses the init wait
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      init_zq <= 1'b0;
    end else if (take && state == ST_RESET) begin
      init_zq <= 1'b1;
    end else if (take_act && req_cmd_in == DLPX_CMD_ZQCL) begin
      init_zq <= 1'b0;
    end
  end

  // cke: falls on entry, rises when the wake clock time is over
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cke_out <= 1'b0;
    end else if (take_act && is_entry) begin
      cke_out <= 1'b0;
    end else if (wake_end) begin
      cke_out <= 1'b1;
    end
  end

  // clock enable: held after entry, restarted before exit
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ck_en_out <= 1'b0;
    end else if (take && (state == ST_RESET || state == ST_LP)) begin
      ck_en_out <= 1'b1;
    end else if (state == ST_LP_HOLD && tm_done[`DLPX_TM_PHASE]) begin
      ck_en_out <= 1'b0;
    end
  end

  // memory reset pin, released by the reset exit request
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      mem_reset_n_out <= 1'b0;
    end else if (take && state == ST_RESET) begin
      mem_reset_n_out <= 1'b1;
    end
  end

  // chip select: command strobe, or held low across power saving exit
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cs_n_out <= 1'b1;
    end else if (take_act) begin
      cs_n_out <= 1'b0;
    end else if (kind == LPK_PWRSAVE && ((state == ST_LP && take) || state == ST_WAKE)) begin
      cs_n_out <= 1'b0;
    end else if (state == ST_CS_HOLD && !tm_done[`DLPX_TM_PHASE]) begin
      cs_n_out <= 1'b0;
    end else begin
      cs_n_out <= 1'b1;
    end
  end

  // command issue towards the memory
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_out <= DLPX_CMD_NOP;
    end else begin
      cmd_valid_out <= take_act;
      cmd_out <= take_act ? req_cmd_in : DLPX_CMD_NOP;
    end
  end

  // completion pulse and status
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      req_done_out <= 1'b0;
      busy_out <= 1'b1;
    end else begin
      req_done_out <= take_act || (wake_end && kind != LPK_PWRSAVE) ||
                      (state == ST_CS_HOLD && tm_done[`DLPX_TM_PHASE]);
      busy_out <= (state != ST_ACTIVE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers
  logic [15:0] gap_cnt;
  logic [15:0] rise_cnt;
  logic [15:0] low_cnt;
  logic [15:0] ck_on_cnt;
  dlpx_cmd_t last_cmd;
  logic last_init;
  logic cmd_init;
  dlpx_lp_kind_t rise_kind;
  logic rise_abort;

  function automatic logic [15:0] sat(input logic [15:0] v);
    sat = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // distance counters for gaps and widths
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      gap_cnt <= 16'hffff;
      rise_cnt <= 16'h0000;
      low_cnt <= 16'h0000;
      ck_on_cnt <= 16'h0000;
      last_cmd <= DLPX_CMD_NOP;
      last_init <= 1'b0;
      cmd_init <= 1'b0;
      rise_kind <= LPK_RESET;
      rise_abort <= 1'b0;
    end else begin
      gap_cnt <= cmd_valid_out ? 16'h0001 : sat(gap_cnt);
      rise_cnt <= wake_end ? 16'h0000 : sat(rise_cnt);
      low_cnt <= cke_out ? 16'h0000 : sat(low_cnt);
      ck_on_cnt <= ck_en_out ? sat(ck_on_cnt) : 16'h0000;
      cmd_init <= init_zq;
      if (cmd_valid_out) begin
        last_cmd <= cmd_out;
        last_init <= cmd_init;
      end
      if (wake_end) begin
        rise_kind <= kind;
        rise_abort <= abort_en_in;
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  a_zq_init_gap: assert property (
    cmd_valid_out && last_cmd == DLPX_CMD_ZQCL && last_init |-> gap_cnt >= 16'h0400)
    else $error("command too soon after init calibration");
  a_zq_long_gap: assert property (
    cmd_valid_out && last_cmd == DLPX_CMD_ZQCL && !last_init |-> gap_cnt >= 16'h0200)
    else $error("command too soon after long calibration");
  a_zq_short_gap: assert property (
    cmd_valid_out && last_cmd == DLPX_CMD_ZQCS |-> gap_cnt >= 16'h0080)
    else $error("command too soon after short calibration");
  a_reset_exit_wait: assert property (
    cmd_valid_out && rise_kind == LPK_RESET |-> rise_cnt >= XPR_CYC)
    else $error("command too soon after reset exit");
  a_srx_plain_wait: assert property (
    cmd_valid_out && rise_kind == LPK_SR && cmd_out inside {DLPX_CMD_PLAIN, DLPX_CMD_DLL}
    |-> rise_cnt >= (rise_abort ? ABORT_CYC : XS_CYC))
    else $error("command too soon after self refresh exit");
  a_srx_fast_wait: assert property (
    cmd_valid_out && rise_kind == LPK_SR |-> rise_cnt >= ABORT_CYC)
    else $error("calibration or mode write too soon after exit");
  a_dll_lock_wait: assert property (
    cmd_valid_out && cmd_out == DLPX_CMD_DLL && rise_kind inside {LPK_SR, LPK_PWRSAVE}
    |-> rise_cnt >= ((rise_kind == LPK_SR) ? DLL_CYC : XMPDLL_CYC))
    else $error("dll command before lock time");
  a_cke_low_width: assert property (
    $rose(cke_out) && kind == LPK_SR |-> low_cnt >= CKESR_CYC + parity_cyc)
    else $error("cke low too short in self refresh");
  a_clock_after_entry: assert property (
    $fell(ck_en_out) |-> low_cnt >= ((kind == LPK_PWRSAVE) ? MPED_CYC : CKV_CYC + parity_cyc))
    else $error("clock stopped too soon after entry");
  a_clock_before_exit: assert property (
    $rose(cke_out) |-> ck_on_cnt >= CKV_CYC && ck_en_out)
    else $error("clock not valid long enough before exit");
  a_cs_low_hold: assert property (
    $rose(cs_n_out) && $past(state) == ST_CS_HOLD
    |-> rise_cnt >= MPX_LH_CYC && rise_cnt <= MPX_MAX_CYC)
    else $error("chip select hold out of window");

  c_init_zq: cover property (cmd_valid_out && cmd_out == DLPX_CMD_ZQCL && cmd_init);
  c_sr_exit: cover property (wake_end && kind == LPK_SR);
  c_ps_exit: cover property ($rose(cs_n_out) && $past(state) == ST_CS_HOLD);
  c_dll_after_sr: cover property (cmd_valid_out && cmd_out == DLPX_CMD_DLL && rise_kind == LPK_SR);
endmodule
`default_nettype wire

// ===== hdl/dlpx_pkg.sv
`default_nettype none
package dlpx_pkg;
  // requests from the user side
  typedef enum logic [3:0] {
    DLPX_CMD_NOP = 4'h0,
    DLPX_CMD_PLAIN = 4'h1,
    DLPX_CMD_DLL = 4'h2,
    DLPX_CMD_ZQCL = 4'h3,
    DLPX_CMD_ZQCS = 4'h4,
    DLPX_CMD_MRS_FAST = 4'h5,
    DLPX_CMD_SRE = 4'h6,
    DLPX_CMD_SRX = 4'h7,
    DLPX_CMD_PWRSAVE_ENTER = 4'h8,
    DLPX_CMD_PWRSAVE_EXIT = 4'h9,
    DLPX_CMD_RESET_EXIT = 4'ha,
    DLPX_CMD_PDE = 4'hb,
    DLPX_CMD_PDX = 4'hc
  } dlpx_cmd_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_WAKE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_LP_HOLD = 3'b011,
    ST_LP = 3'b100,
    ST_CS_HOLD = 3'b101
  } dlpx_state_t;
  // which low power condition is being entered or left
  typedef enum logic [1:0] {
    LPK_RESET = 2'b00,
    LPK_SR = 2'b01,
    LPK_PD = 2'b10,
    LPK_PWRSAVE = 2'b11
  } dlpx_lp_kind_t;
endpackage
`default_nettype wire

// ===== hdl/dlpx_wait_timer.sv
`include "dlpx_consts.svh"
`default_nettype none
module dlpx_wait_timer
  import dlpx_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic load_in,
  input wire logic [`DLPX_CNT_W-1:0] value_in,
  output logic done_out
);
  logic [`DLPX_CNT_W-1:0] count;
  // down counter, parks at zero
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      count <= '0;
    end else if (load_in) begin
      count <= value_in;
    end else if (count != '0) begin
      count <= count - `DLPX_CNT_W'(1);
    end
  end
  assign done_out = (count == '0);
endmodule
`default_nettype wire
